//--- dv/acm_flash_model.sv
// Purpose: Behavioural serial flash facing the configuration master
// Assumes: Read opcode then 24-bit address, MSB first
// Notes:   Released data pin shows its pull-up level
`timescale 1ns/1ps
module acm_flash_model #(
  parameter int MEM_BYTES = 64
) (
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        cmd_i,
  output logic             data_o,
  output logic [31:0]      hdr_o,
  output int               rise_cnt_o
);
  logic [7:0] mem [MEM_BYTES];
  int         idx;
  logic       drive_r;
  logic       bit_r;

  initial begin
    rise_cnt_o = 0;
    hdr_o = '0;
    idx = 0;
    drive_r = 1'b0;
    bit_r = 1'b1;
  end

  // ==========================================================================
  // Serial side
  assign data_o = (drive_r && !cs_n_i) ? bit_r : 1'b1;

  always @(negedge cs_n_i) begin
    rise_cnt_o <= 0;
    hdr_o <= '0;
    drive_r <= 1'b0;
  end

  // Edges judged 1 ns late: select and the released clock pin move in one step,
  // so a zero-time glitch on the clock pin must not count as a rise or fall
  always @(posedge sclk_i) begin
    #1;
    if (!cs_n_i) begin
      if (rise_cnt_o < 32)
        hdr_o <= {hdr_o[30:0], cmd_i};
      rise_cnt_o <= rise_cnt_o + 1;
    end
  end

  // Data changes on falls only, after the whole header; image spans the chain
  always @(negedge sclk_i) begin
    #1;
    if (!cs_n_i && rise_cnt_o >= 32) begin
      idx = rise_cnt_o - 32;
      bit_r <= mem[(idx / 8) % MEM_BYTES][7 - (idx % 8)];
      drive_r <= 1'b1;
    end
  end
endmodule

//--- dv/testbench.sv
// Purpose: Self-checking bench of the configuration master
// Assumes: Small image size so a load takes under a thousand cycles
// Notes:   Pins resolve to their pull-up level while released
`timescale 1ns/1ps
module testbench;
  localparam int          NB   = 20;
  localparam logic [23:0] ADDR = 24'h01_2340;

  logic        mclk;
  logic        nrst;
  logic [3:0]  scheme;
  logic        jtag;
  logic        rld_n;
  logic        cmpr;
  logic        rdy;
  logic        other_pull;
  logic        sclk;
  logic        sclk_oe;
  logic        cs_n;
  logic        cs_oe;
  logic        cmd;
  logic        cmd_oe;
  logic        ld_od;
  logic        ld_oe;
  logic        cen_n;
  logic [7:0]  cfg_data;
  logic        cfg_valid;
  logic        init;
  logic        data_pin;
  logic [31:0] hdr;
  int          rises;
  int          n_mismatch;
  int          n_checks;
  logic [7:0]  got [$];

  wire sclk_pin = sclk_oe ? sclk : 1'b1;
  wire cs_n_pin = cs_oe ? cs_n : 1'b1;
  wire cmd_pin  = cmd_oe ? cmd : 1'b1;
  wire ld_line  = !((ld_oe && !ld_od) || other_pull);

  acm_config_master #(.IMAGE_BYTES(32'h0000_0014), .START_ADDR(ADDR)) dut_u (
    .mclk_i(mclk), .nrst_i(nrst), .scheme_select_i(scheme), .jtag_config_i(jtag),
    .reload_request_n_i(rld_n), .compressed_i(cmpr), .flash_data_i(data_pin),
    .load_complete_od_i(ld_line), .cfg_ready_i(rdy), .serial_config_clock_o(sclk),
    .serial_config_clock_oe_o(sclk_oe), .flash_chip_select_n_o(cs_n),
    .flash_chip_select_n_oe_o(cs_oe), .cmd_shift_out_o(cmd), .cmd_shift_out_oe_o(cmd_oe),
    .load_complete_od_o(ld_od), .load_complete_od_oe_o(ld_oe), .chain_enable_n_o(cen_n),
    .cfg_data_o(cfg_data), .cfg_valid_o(cfg_valid), .init_start_o(init));

  acm_flash_model #(.MEM_BYTES(NB)) flash_u (
    .sclk_i(sclk_pin), .cs_n_i(cs_n_pin), .cmd_i(cmd_pin),
    .data_o(data_pin), .hdr_o(hdr), .rise_cnt_o(rises));

  // ==========================================================================
  // Clock, collector and watchdog
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (nrst && cfg_valid === 1'b1 && rdy)
      got.push_back(cfg_data);
  end

  always @(negedge mclk) begin
    if (nrst)
      check(cen_n, ld_oe);
  end

  initial begin
    #500us;
    n_mismatch++;
    wrap_up();
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    n_checks++;
    if (act !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic check_bytes(input logic [7:0] exp_q [$]);
    check(got.size(), exp_q.size());
    foreach (exp_q[i])
      if (i < got.size())
        check(got[i], exp_q[i]);
  endtask

  task automatic start_load(input logic [3:0] sch, input logic cmp, input logic jt);
    @(posedge mclk);
    rld_n <= 1'b0;
    scheme <= sch;
    cmpr <= cmp;
    jtag <= jt;
    repeat (6) @(posedge mclk);
    got.delete();
    rld_n <= 1'b1;
  endtask

  // Bounded waits: first for the select, then for the line release
  task automatic wait_done();
    int n;
    n = 0;
    while (cs_n_pin !== 1'b0 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    check(n < 100, 1);
    n = 0;
    while (ld_oe !== 1'b0 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    check(n < 20000, 1);
  endtask

  task automatic wait_init();
    int n;
    n = 0;
    while (init !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    check(init, 1);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_refuse();
    logic [4:0] cases [5] = '{5'h00, 5'h01, 5'h04, 5'h0d, 5'h12};
    foreach (cases[i]) begin
      start_load(cases[i][3:0], 1'b0, cases[i][4]);
      repeat (60) @(posedge mclk);
      check({sclk_oe, cs_oe, cmd_oe, cs_n_pin}, 4'h1);
    end
  endtask

  task automatic t_plain();
    logic [7:0] exp_q [$];
    time        t0;
    for (int i = 0; i < NB; i++) begin
      flash_u.mem[i] = 8'h5a ^ 8'(i * 29);
      exp_q.push_back(8'h5a ^ 8'(i * 29));
    end
    other_pull <= 1'b1;
    rdy <= 1'b1;
    start_load(4'h2, 1'b0, 1'b0);
    @(posedge sclk);
    t0 = $time;
    @(posedge sclk);
    check(($time - t0) >= 25 && ($time - t0) <= 50, 1);
    wait_done();
    check(hdr, {8'h03, ADDR});
    check(rises, 32 + 8 * NB);
    repeat (40) @(posedge mclk);
    check_bytes(exp_q);
    check({sclk_oe, cs_oe, cmd_oe}, 3'h0);
    check({sclk_pin, cs_n_pin, cmd_pin}, 3'h7);
    check(cen_n, 0);
    check(init, 0);
    check(ld_od, 0);
    other_pull <= 1'b0;
    wait_init();
  endtask

  task automatic t_stall();
    logic [7:0] exp_q [$];
    for (int i = 0; i < NB; i++)
      exp_q.push_back(flash_u.mem[i]);
    rdy <= 1'b0;
    start_load(4'h3, 1'b0, 1'b0);
    repeat (1500) @(posedge mclk);
    check(ld_oe, 1);
    check(cs_n_pin, 0);
    check(got.size(), 0);
    rdy <= 1'b1;
    wait_done();
    wait_init();
    check_bytes(exp_q);
  endtask

  task automatic t_compressed();
    logic [7:0] exp_q [$];
    for (int k = 0; k < NB / 2; k++) begin
      flash_u.mem[2 * k] = 8'(k % 3);
      flash_u.mem[2 * k + 1] = 8'hc0 + 8'(k);
      repeat (k % 3 + 1) exp_q.push_back(8'hc0 + 8'(k));
    end
    start_load(4'h2, 1'b1, 1'b0);
    wait_done();
    wait_init();
    check_bytes(exp_q);
  endtask

  task automatic t_abort();
    start_load(4'h3, 1'b0, 1'b0);
    repeat (300) @(posedge mclk);
    check(ld_oe, 1);
    rld_n <= 1'b0;
    repeat (6) @(posedge mclk);
    check({sclk_oe, cs_oe, cmd_oe, cs_n_pin}, 4'h1);
    check(init, 0);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    nrst = 1'b0;
    scheme = 4'h0;
    jtag = 1'b0;
    rld_n = 1'b1;
    cmpr = 1'b0;
    rdy = 1'b1;
    other_pull = 1'b0;
    repeat (5) @(posedge mclk);
    check({sclk_oe, cs_oe, cmd_oe, ld_oe, cen_n}, 5'h03);
    nrst <= 1'b1;
    t_refuse();
    t_plain();
    t_stall();
    t_compressed();
    t_abort();
    wrap_up();
  end
endmodule

//--- logic/acm_config_master.sv
// Purpose: Active serial configuration master: reads the image from a serial flash
// Assumes: Straps and the load-complete line are asynchronous pins
// Notes:   Serial clock is derived from the core clock, no external source
//
// Functional notes
// - Serial clock between 20 and 40 MHz
// - Serial clock derived internally, no external clock
// - Read, decompress, write configuration cells
// - Outputs change and data sampled on fall
// - Flash select held low while configuring
// - Commands and address shifted on command output
// - Release load-complete once all bits received
// - Initialization waits for load-complete sensed high
// - Flash pins tri-stated after configuration
// - Chain-enable driven low after own image
// - Active serial strap makes this the chain master
// - Load-complete released with chain-enable assertion
// - Load-complete held low until own image done
// - Chain starts initialization on shared line high
// - Last chain-enable may be left unconnected
// - Scheme 0010 or 0011 selects active serial
// - JTAG configuration overrides scheme straps
`timescale 1ns/1ps
module acm_config_master #(
  parameter logic [31:0]           IMAGE_BYTES = 32'h0000_0400,
  parameter logic [acm_pkg::ADDR_W-1:0] START_ADDR = 24'h00_0000
) (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic [3:0] scheme_select_i,
  input  wire logic       jtag_config_i,
  input  wire logic       reload_request_n_i,
  input  wire logic       compressed_i,
  input  wire logic       flash_data_i,
  input  wire logic       load_complete_od_i,
  input  wire logic       cfg_ready_i,
  output logic            serial_config_clock_o,
  output logic            serial_config_clock_oe_o,
  output logic            flash_chip_select_n_o,
  output logic            flash_chip_select_n_oe_o,
  output logic            cmd_shift_out_o,
  output logic            cmd_shift_out_oe_o,
  output logic            load_complete_od_o,
  output logic            load_complete_od_oe_o,
  output logic            chain_enable_n_o,
  output logic [7:0]      cfg_data_o,
  output logic            cfg_valid_o,
  output logic            init_start_o
);

  // ==========================================================================
  // Scheme decode
  function automatic logic is_as_scheme(input logic [3:0] sel);
    is_as_scheme = (sel == acm_pkg::SCHEME_AS_33) || (sel == acm_pkg::SCHEME_AS_30);
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic [7:0] sync1_r, sync2_r;
  logic       reload_s, done_s, data_s, jtag_s;
  logic [3:0] scheme_s;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {reload_request_n_i, load_complete_od_i, flash_data_i, jtag_config_i,
                  scheme_select_i};
      sync2_r <= sync1_r;
    end
  end

  assign {reload_s, done_s, data_s, jtag_s, scheme_s} = sync2_r;

  // ==========================================================================
  // Loader state
  acm_pkg::acm_state_t st_r, st_nxt;
  logic        sclk_r, sclk_nxt;
  logic [1:0]  hcnt_r, hcnt_nxt;
  logic [5:0]  bit_r, bit_nxt;
  logic [31:0] sh_r, sh_nxt;
  logic [7:0]  byte_r, byte_nxt;
  logic [31:0] bcnt_r, bcnt_nxt;
  logic        cs_n_r, cs_n_nxt, cmd_r, cmd_nxt, oe_r, oe_nxt;
  logic        dn_oe_r, dn_oe_nxt, ceo_n_r, ceo_n_nxt, init_r, init_nxt, od_lvl_r;
  logic        edge_due, fall, hold, push, drained;
  logic        fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0]  fifo_out_data, cap_byte;

  assign edge_due = hcnt_r == acm_pkg::HALF_LAST;
  // Back-pressure: the clock stays high before a byte-completing fall
  assign hold     = st_r == acm_pkg::ST_DATA && bit_r == acm_pkg::BYTE_LAST && !fifo_in_ready;
  assign fall     = sclk_r && edge_due && !hold;
  assign cap_byte = {byte_r[acm_pkg::BYTE_W-2:0], data_s};
  assign push     = st_r == acm_pkg::ST_DATA && fall && bit_r == acm_pkg::BYTE_LAST;

  always_comb begin
    st_nxt    = st_r;
    sclk_nxt  = sclk_r;
    hcnt_nxt  = hcnt_r;
    bit_nxt   = bit_r;
    sh_nxt    = sh_r;
    byte_nxt  = byte_r;
    bcnt_nxt  = bcnt_r;
    cs_n_nxt  = cs_n_r;
    cmd_nxt   = cmd_r;
    oe_nxt    = oe_r;
    dn_oe_nxt = dn_oe_r;
    ceo_n_nxt = ceo_n_r;
    init_nxt  = init_r;
    if (st_r == acm_pkg::ST_CMD || st_r == acm_pkg::ST_DATA) begin
      // Divider from the core clock gives the serial clock rate
      if (edge_due && !(sclk_r && hold)) begin
        sclk_nxt = !sclk_r;
        hcnt_nxt = '0;
      end else if (!edge_due) begin
        hcnt_nxt = hcnt_r + 2'(1);
      end
    end
    case (st_r)
      acm_pkg::ST_IDLE: begin
        if (reload_s && !jtag_s && is_as_scheme(scheme_s)) begin
          st_nxt    = acm_pkg::ST_CMD;
          oe_nxt    = 1'b1;
          cs_n_nxt  = 1'b0;
          cmd_nxt   = acm_pkg::READ_OPCODE[7];
          sh_nxt    = {acm_pkg::READ_OPCODE[6:0], START_ADDR, 1'b0};
          bit_nxt   = '0;
          hcnt_nxt  = '0;
          sclk_nxt  = 1'b0;
          bcnt_nxt  = '0;
          dn_oe_nxt = 1'b1;
          ceo_n_nxt = 1'b1;
          init_nxt  = 1'b0;
        end
      end
      acm_pkg::ST_CMD: begin
        if (fall) begin
          // Flash samples on the next rise, so the bit is changed on this fall
          cmd_nxt = sh_r[31];
          sh_nxt  = {sh_r[30:0], 1'b0};
          bit_nxt = bit_r + 6'(1);
          if (bit_r == acm_pkg::CMD_LAST) begin
            st_nxt  = acm_pkg::ST_DATA;
            bit_nxt = '0;
          end
        end
      end
      acm_pkg::ST_DATA: begin
        if (fall) begin
          // Synchronised sample reflects the bit driven at the previous fall
          byte_nxt = cap_byte;
          bit_nxt  = bit_r + 6'(1);
          if (push) begin
            bit_nxt  = '0;
            bcnt_nxt = bcnt_r + 32'h0000_0001;
            if (bcnt_r == IMAGE_BYTES - 32'h0000_0001) begin
              st_nxt    = acm_pkg::ST_DONE;
              sclk_nxt  = 1'b0;
              cs_n_nxt  = 1'b1;
              oe_nxt    = 1'b0;
              dn_oe_nxt = 1'b0;
              ceo_n_nxt = 1'b0;
            end
          end
        end
      end
      acm_pkg::ST_DONE: begin
        if (done_s && drained) begin
          st_nxt   = acm_pkg::ST_USER;
          init_nxt = 1'b1;
        end
      end
      acm_pkg::ST_USER: begin
        init_nxt = 1'b1;
      end
      default: begin
        st_nxt = acm_pkg::ST_IDLE;
      end
    endcase
    // A reload request aborts any load and waits for its release
    if (!reload_s) begin
      st_nxt    = acm_pkg::ST_IDLE;
      sclk_nxt  = 1'b0;
      cs_n_nxt  = 1'b1;
      oe_nxt    = 1'b0;
      dn_oe_nxt = 1'b1;
      ceo_n_nxt = 1'b1;
      init_nxt  = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st_r     <= acm_pkg::ST_IDLE;
      sclk_r   <= 1'b0;
      hcnt_r   <= '0;
      bit_r    <= '0;
      sh_r     <= '0;
      byte_r   <= '0;
      bcnt_r   <= '0;
      cs_n_r   <= 1'b1;
      cmd_r    <= 1'b0;
      oe_r     <= 1'b0;
      dn_oe_r  <= 1'b1;
      ceo_n_r  <= 1'b1;
      init_r   <= 1'b0;
      od_lvl_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      sclk_r   <= sclk_nxt;
      hcnt_r   <= hcnt_nxt;
      bit_r    <= bit_nxt;
      sh_r     <= sh_nxt;
      byte_r   <= byte_nxt;
      bcnt_r   <= bcnt_nxt;
      cs_n_r   <= cs_n_nxt;
      cmd_r    <= cmd_nxt;
      oe_r     <= oe_nxt;
      dn_oe_r  <= dn_oe_nxt;
      ceo_n_r  <= ceo_n_nxt;
      init_r   <= init_nxt;
      od_lvl_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Byte buffer
  acm_fifo #(
    .WIDTH(acm_pkg::BYTE_W),
    .DEPTH(acm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .nrst_i      (nrst_i),
    .flush_i     (!reload_s),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (cap_byte),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // ==========================================================================
  // Decompressor and cell writer port
  // Compressed images are count/value pairs, each giving count+1 copies
  logic       vld_r, vld_nxt, run_r, run_nxt, have_r, have_nxt, out_ok;
  logic [7:0] dat_r, dat_nxt, rep_r, rep_nxt, val_r, val_nxt;

  assign out_ok  = !vld_r || cfg_ready_i;
  assign drained = !run_r && !have_r && !fifo_out_valid && !vld_r;

  always_comb begin
    vld_nxt        = vld_r && !cfg_ready_i;
    dat_nxt        = dat_r;
    rep_nxt        = rep_r;
    val_nxt        = val_r;
    run_nxt        = run_r;
    have_nxt       = have_r;
    fifo_out_ready = 1'b0;
    if (run_r) begin
      if (out_ok) begin
        vld_nxt = 1'b1;
        dat_nxt = val_r;
        if (rep_r == '0) begin
          run_nxt = 1'b0;
        end else begin
          rep_nxt = rep_r - 8'h01;
        end
      end
    end else if (compressed_i) begin
      fifo_out_ready = 1'b1;
      if (fifo_out_valid && have_r) begin
        val_nxt  = fifo_out_data;
        run_nxt  = 1'b1;
        have_nxt = 1'b0;
      end else if (fifo_out_valid) begin
        rep_nxt  = fifo_out_data;
        have_nxt = 1'b1;
      end
    end else begin
      fifo_out_ready = out_ok;
      if (out_ok && fifo_out_valid) begin
        vld_nxt = 1'b1;
        dat_nxt = fifo_out_data;
      end
    end
    if (!reload_s) begin
      vld_nxt  = 1'b0;
      run_nxt  = 1'b0;
      have_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      vld_r  <= 1'b0;
      dat_r  <= '0;
      rep_r  <= '0;
      val_r  <= '0;
      run_r  <= 1'b0;
      have_r <= 1'b0;
    end else begin
      vld_r  <= vld_nxt;
      dat_r  <= dat_nxt;
      rep_r  <= rep_nxt;
      val_r  <= val_nxt;
      run_r  <= run_nxt;
      have_r <= have_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign serial_config_clock_o    = sclk_r;
  assign serial_config_clock_oe_o = oe_r;
  assign flash_chip_select_n_o    = cs_n_r;
  assign flash_chip_select_n_oe_o = oe_r;
  assign cmd_shift_out_o          = cmd_r;
  assign cmd_shift_out_oe_o       = oe_r;
  assign load_complete_od_o       = od_lvl_r;
  assign load_complete_od_oe_o    = dn_oe_r;
  assign chain_enable_n_o         = ceo_n_r;
  assign cfg_data_o               = dat_r;
  assign cfg_valid_o              = vld_r;
  assign init_start_o             = init_r;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  a_sclk_rate: assert property ($rose(serial_config_clock_o) && reload_s |=> sclk_r)
    else $error("serial clock high phase too short");
  a_sclk_low_phase: assert property ($fell(serial_config_clock_o) && st_r == acm_pkg::ST_CMD
      |=> !serial_config_clock_o ##1 (serial_config_clock_o || st_r != acm_pkg::ST_CMD))
    else $error("serial clock low phase not two cycles");
  a_cmd_on_fall: assert property ($changed(cmd_shift_out_o) && $past(st_r) == acm_pkg::ST_CMD
      |-> $fell(serial_config_clock_o))
    else $error("command bit changed off a falling edge");
  a_select_low: assert property (st_r inside {acm_pkg::ST_CMD, acm_pkg::ST_DATA}
      |-> !flash_chip_select_n_o && flash_chip_select_n_oe_o && load_complete_od_oe_o)
    else $error("select or load-complete hold lost during load");
  a_opcode_first: assert property ($fell(flash_chip_select_n_o)
      |-> cmd_shift_out_o == acm_pkg::READ_OPCODE[7])
    else $error("first command bit is not the opcode msb");
  a_release_chain: assert property ($fell(load_complete_od_oe_o)
      |-> $fell(chain_enable_n_o) && !serial_config_clock_oe_o)
    else $error("load-complete release and chain enable out of step");
  a_chain_cause: assert property ($fell(chain_enable_n_o)
      |-> $past(push) && $past(bcnt_r) == IMAGE_BYTES - 32'h0000_0001)
    else $error("chain enable asserted before image complete");
  a_init_wait: assert property ($rose(init_start_o) |-> $past(done_s) && $past(drained))
    else $error("initialization started without load-complete high");
  a_pins_released: assert property (st_r inside {acm_pkg::ST_DONE, acm_pkg::ST_USER}
      |-> !serial_config_clock_oe_o && !flash_chip_select_n_oe_o && !cmd_shift_out_oe_o)
    else $error("flash pins still driven after load");
  a_jtag_idle: assert property (st_r == acm_pkg::ST_IDLE && (jtag_s || !is_as_scheme(scheme_s))
      |=> st_r == acm_pkg::ST_IDLE)
    else $error("load started under jtag or non-serial scheme");

endmodule

//--- logic/acm_fifo.sv
// Purpose: Byte buffer between the serial capture and the cell writer
// Assumes: DEPTH is a power of two
// Notes:   in_ready_o drops when full; the capture side stalls the serial clock
`timescale 1ns/1ps
module acm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             do_wr, do_rd;

  assign in_ready_o  = cnt_r != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_r != '0;
  assign out_data_o  = mem_r[rd_r];
  assign do_wr       = in_valid_i && in_ready_o;
  assign do_rd       = out_valid_o && out_ready_i;

  always_comb begin
    wr_nxt  = do_wr ? wr_r + AW'(1) : wr_r;
    rd_nxt  = do_rd ? rd_r + AW'(1) : rd_r;
    cnt_nxt = cnt_r;
    if (do_wr && !do_rd) begin
      cnt_nxt = cnt_r + (AW+1)'(1);
    end else if (do_rd && !do_wr) begin
      cnt_nxt = cnt_r - (AW+1)'(1);
    end
    if (flush_i) begin
      wr_nxt  = '0;
      rd_nxt  = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (do_wr) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

endmodule

//--- logic/acm_pkg.sv
// Purpose: Shared constants and types of the active serial configuration master
// Assumes: Core clock of 100 MHz; one read command per load
// Notes:   The serial clock half-period count is derived here from the clock rates; the framing counts and FIFO depth are fixed
package acm_pkg;

  // ==========================================================================
  // Clock rates and serial clock derivation
  localparam int MCLK_MHZ     = 100;
  localparam int SCLK_MAX_MHZ = 40;
  localparam int SCLK_TYP_MHZ = 30;
  localparam int SCLK_MIN_MHZ = 20;
  // Half period rounded up so the serial clock never exceeds its maximum rate
  localparam int HALF_CYC = (MCLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam logic [1:0] HALF_LAST = 2'(HALF_CYC - 1);

  // ==========================================================================
  // Scheme straps
  localparam logic [3:0] SCHEME_AS_33 = 4'h2;
  localparam logic [3:0] SCHEME_AS_30 = 4'h3;

  // ==========================================================================
  // Flash command framing
  localparam int         ADDR_W      = 24;
  localparam logic [7:0] READ_OPCODE = 8'h03;
  localparam logic [5:0] CMD_LAST    = 6'h1f;
  localparam int         BYTE_W      = 8;
  localparam logic [5:0] BYTE_LAST   = 6'h07;
  localparam int         FIFO_DEPTH  = 16;

  // ==========================================================================
  // Loader states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD  = 5'h02,
    ST_DATA = 5'h04,
    ST_DONE = 5'h08,
    ST_USER = 5'h10
  } acm_state_t;

endpackage
